// File: verilog/hdfu_defs.vh
// constants for the half-byte data format unit
`ifndef HDFU_DEFS_VH
`define HDFU_DEFS_VH
`define HDFU_NIB_W 4
`define HDFU_HB_W 5
`define HDFU_BYTE_W 8
`define HDFU_ADDR_W 14
`define HDFU_LEN_W 8
`define HDFU_DIGIT_MAX 4'h9
`define HDFU_SIGN_MIN 4'hA
`define HDFU_PK_MAXLEN 8'h0F
`define HDFU_ZN_MAXLEN 8'h0F
`define HDFU_LG_MAXLEN 8'hFF
`define HDFU_PRI_PLUS 4'hC
`define HDFU_PRI_MINUS 4'hD
`define HDFU_ALT_PLUS 4'hA
`define HDFU_ALT_MINUS 4'hB
`define HDFU_FMT_PACKED 2'h0
`define HDFU_FMT_ZONED 2'h1
`define HDFU_FMT_LOGIC 2'h2
`define HDFU_FMT_IO 2'h3
`endif

// File: verilog/hdfu_halfbyte.v
// half-byte parity generator and checker
`timescale 1ns/10ps
`default_nettype none
module hdfu_halfbyte (
	input wire [3:0] value_in,
	input wire [4:0] hb_in,
	output wire [4:0] hb_out,
	output wire par_err
);
	// odd total count: check set when value bits even
	assign hb_out = {~(^value_in), value_in};
	assign par_err = ~(^hb_in);
endmodule // hdfu_halfbyte
`default_nettype wire

// File: verilog/hdfu_unit.v
// half-byte data format unit: parity, field sequencing, format checks
// Function
// - storage moves whole bytes; processing works on half-bytes
// - half-byte is four weighted value bits plus one check bit
// - half-byte with even set-bit count flags a parity error
// - generated check bit set when value bit count is even
// - byte split into upper and lower halves, each with check bit
// - stored byte carries eight value bits, all 256 patterns allowed
// - internal fields start at highest address and walk downward
// - I/O fields start at lowest address and walk upward
// - I/O transfer stops after the instructed byte count
// - fixed-point operand: sign bit plus fifteen-bit integer
// - negative fixed-point values are two's complement
// - packed: two digits per byte, low byte digit then sign
// - packed lengths 1 to 16 bytes, 1 to 31 digits
// - zoned: digit right, zone left, low byte sign left
// - zoned lengths 1 to 16 bytes
// - digit nibbles 0000..1001 valid, 1010..1111 invalid
// - sign nibbles valid only 1010..1111
// - sign plus/minus decoding depends on code mode
// - zoned zone nibbles accept any value
// - decimal arithmetic takes packed operands only; ARITH_OP rejects zoned fields but not logical or I/O fields
// - logical fields up to 256 bytes, left to right, any pattern
`timescale 1ns/10ps
`include "hdfu_defs.vh"
`default_nettype none
module hdfu_unit (
	input wire CLK,
	input wire SYS_RST,
	input wire START,
	input wire [1:0] FORMAT,
	input wire ALT_CODE,
	input wire ARITH_OP,
	input wire [13:0] START_ADDR,
	input wire [7:0] LENGTH_M1,
	input wire [7:0] MEM_RDATA,
	input wire [9:0] HB_IN,
	input wire HB_VALID,
	input wire ERR_CLEAR,
	input wire [15:0] FX_A,
	input wire [15:0] FX_B,
	input wire FX_SUB,
	output reg [13:0] MEM_ADDR,
	output wire MEM_RD,
	output reg [9:0] HB_OUT,
	output reg HB_OUT_VALID,
	output reg BUSY,
	output reg DONE,
	output reg FMT_ERR,
	output reg MINUS,
	output reg PARITY_ERR,
	output reg [15:0] FX_RESULT,
	output reg FX_OVERFLOW
);
	localparam ST_IDLE = 2'h0;
	localparam ST_RUN = 2'h1;
	localparam ST_DONE = 2'h2;

	reg [1:0] state_ff, nxt_state;
	reg [13:0] addr_ff, nxt_addr;
	reg [7:0] left_ff, nxt_left;
	reg [1:0] fmt_ff;
	reg alt_ff;
	reg first_ff;
	reg err_ff, nxt_err;
	reg minus_ff, nxt_minus;
	reg sticky_ff;

	// upper and lower half of each byte
	wire [3:0] upper_val = MEM_RDATA[7:4];
	wire [3:0] lower_val = MEM_RDATA[3:0];
	wire [4:0] gen_hb [0:1];
	wire [1:0] chk_err;
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_half
			hdfu_halfbyte u_hb (
				.value_in(MEM_RDATA[gi*4 +: 4]),
				.hb_in(HB_IN[gi*5 +: 5]),
				.hb_out(gen_hb[gi]),
				.par_err(chk_err[gi])
			);
		end
	endgenerate
	// {upper check, upper value} {lower check, lower value}
	wire [9:0] byte_hb = {gen_hb[1], gen_hb[0]};

	wire dig_bad_u = (upper_val > `HDFU_DIGIT_MAX);
	wire dig_bad_l = (lower_val > `HDFU_DIGIT_MAX);
	wire sign_bad_l = (lower_val < `HDFU_SIGN_MIN);
	wire sign_bad_u = (upper_val < `HDFU_SIGN_MIN);

	function sign_is_minus;
		input [3:0] s;
		input alt;
		begin
			if (alt)
				sign_is_minus = (s == `HDFU_ALT_MINUS) ||
					(s == `HDFU_PRI_MINUS);
			else
				sign_is_minus = (s == `HDFU_PRI_MINUS);
		end
	endfunction

	wire is_io = (fmt_ff == `HDFU_FMT_IO) ||
		(fmt_ff == `HDFU_FMT_LOGIC);
	wire last_byte = (left_ff == 8'h00);

	reg len_bad;
	always @* begin
		case (FORMAT)
		`HDFU_FMT_PACKED: len_bad = (LENGTH_M1 > `HDFU_PK_MAXLEN);
		`HDFU_FMT_ZONED: len_bad = (LENGTH_M1 > `HDFU_ZN_MAXLEN) ||
			ARITH_OP;
		default: len_bad = (LENGTH_M1 > `HDFU_LG_MAXLEN);
		endcase
	end

	// per-byte format check; first byte of internal field is low order
	reg byte_err;
	always @* begin
		byte_err = 1'b0;
		case (fmt_ff)
		`HDFU_FMT_PACKED: begin
			if (first_ff)
				byte_err = dig_bad_u | sign_bad_l;
			else
				byte_err = dig_bad_u | dig_bad_l;
		end
		`HDFU_FMT_ZONED: begin
			if (first_ff)
				byte_err = dig_bad_l | sign_bad_u;
			else
				byte_err = dig_bad_l;
		end
		default: byte_err = 1'b0;
		endcase
	end

	always @* begin
		nxt_state = state_ff;
		nxt_addr = addr_ff;
		nxt_left = left_ff;
		nxt_err = err_ff;
		nxt_minus = minus_ff;
		case (state_ff)
		ST_IDLE: begin
			if (START) begin
				nxt_state = len_bad ? ST_DONE : ST_RUN;
				nxt_addr = START_ADDR;
				nxt_left = LENGTH_M1;
				nxt_err = len_bad;
				nxt_minus = 1'b0;
			end
		end
		ST_RUN: begin
			nxt_err = err_ff | byte_err;
			if (first_ff && fmt_ff == `HDFU_FMT_PACKED)
				nxt_minus = sign_is_minus(lower_val, alt_ff);
			if (first_ff && fmt_ff == `HDFU_FMT_ZONED)
				nxt_minus = sign_is_minus(upper_val, alt_ff);
			if (is_io)
				nxt_addr = addr_ff + 14'h0001;
			else
				nxt_addr = addr_ff - 14'h0001;
			nxt_left = left_ff - 8'h01;
			if (last_byte)
				nxt_state = ST_DONE;
		end
		ST_DONE: nxt_state = ST_IDLE;
		default: nxt_state = ST_IDLE;
		endcase
	end

	assign MEM_RD = (state_ff == ST_RUN);

	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			state_ff <= ST_IDLE;
			addr_ff <= 14'h0000;
			left_ff <= 8'h00;
			fmt_ff <= 2'h0;
			alt_ff <= 1'b0;
			first_ff <= 1'b0;
			err_ff <= 1'b0;
			minus_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			addr_ff <= nxt_addr;
			left_ff <= nxt_left;
			err_ff <= nxt_err;
			minus_ff <= nxt_minus;
			if (state_ff == ST_IDLE && START) begin
				fmt_ff <= FORMAT;
				alt_ff <= ALT_CODE;
				first_ff <= 1'b1;
			end else if (state_ff == ST_RUN) begin
				first_ff <= 1'b0;
			end
		end
	end

	// registered outputs
	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			MEM_ADDR <= 14'h0000;
			HB_OUT <= 10'h000;
			HB_OUT_VALID <= 1'b0;
			BUSY <= 1'b0;
			DONE <= 1'b0;
			FMT_ERR <= 1'b0;
			MINUS <= 1'b0;
		end else begin
			MEM_ADDR <= nxt_addr;
			HB_OUT_VALID <= MEM_RD;
			if (MEM_RD)
				HB_OUT <= byte_hb;
			BUSY <= (nxt_state == ST_RUN);
			DONE <= (state_ff == ST_DONE);
			if (state_ff == ST_DONE) begin
				FMT_ERR <= err_ff;
				MINUS <= minus_ff;
			end
		end
	end

	// sticky parity flag; a new error wins over a clear
	wire hb_err = HB_VALID & (|chk_err);
	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			sticky_ff <= 1'b0;
			PARITY_ERR <= 1'b0;
		end else begin
			sticky_ff <= hb_err | (sticky_ff & ~ERR_CLEAR);
			PARITY_ERR <= hb_err | (sticky_ff & ~ERR_CLEAR);
		end
	end

	// fixed point: sign plus fifteen bits, two's complement
	wire [15:0] fx_b_eff = FX_SUB ? ~FX_B : FX_B;
	wire [16:0] fx_sum = {1'b0, FX_A} + {1'b0, fx_b_eff} +
		{16'h0000, FX_SUB};
	wire fx_ovf = (FX_A[15] == fx_b_eff[15]) &&
		(fx_sum[15] != FX_A[15]);
	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			FX_RESULT <= 16'h0000;
			FX_OVERFLOW <= 1'b0;
		end else begin
			FX_RESULT <= fx_sum[15:0];
			FX_OVERFLOW <= fx_ovf;
		end
	end
endmodule // hdfu_unit
`default_nettype wire

// File: verif/hdfu_chk_assertions.sv
// concurrent checks on the format unit ports
`timescale 1ns/10ps
`default_nettype none
module hdfu_chk (
	input wire CLK,
	input wire SYS_RST,
	input wire START,
	input wire [1:0] FORMAT,
	input wire [13:0] START_ADDR,
	input wire [7:0] LENGTH_M1,
	input wire [9:0] HB_IN,
	input wire HB_VALID,
	input wire ERR_CLEAR,
	input wire [13:0] MEM_ADDR,
	input wire MEM_RD,
	input wire [9:0] HB_OUT,
	input wire HB_OUT_VALID,
	input wire BUSY,
	input wire DONE,
	input wire FMT_ERR,
	input wire PARITY_ERR
);
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	logic down_ff;
	wire go = START && !BUSY;
	wire bad = go && FORMAT == 2'h0 && LENGTH_M1 > 8'h0F;
	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST)
			down_ff <= 1'b0;
		else if (go)
			down_ff <= !FORMAT[1];
	end
	sequence s_io4;
		MEM_RD [*4] ##1 !MEM_RD;
	endsequence
	property p_par_set;
		HB_VALID && (~^HB_IN[9:5] || ~^HB_IN[4:0]) |=> PARITY_ERR;
	endproperty
	a_par_set: assert property (p_par_set)
		else $error("parity error not flagged");
	property p_sticky;
		PARITY_ERR && !ERR_CLEAR |=> PARITY_ERR;
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("parity flag dropped");
	property p_hb_gen;
		HB_OUT_VALID |-> ^HB_OUT[9:5] && ^HB_OUT[4:0];
	endproperty
	a_hb_gen: assert property (p_hb_gen)
		else $error("generated half-byte parity even");
	property p_start_rd;
		go && FORMAT[1] |=> MEM_RD && MEM_ADDR == $past(START_ADDR);
	endproperty
	a_start_rd: assert property (p_start_rd)
		else $error("field walk did not start at address");
	property p_dir;
		MEM_RD && $past(MEM_RD) |-> MEM_ADDR ==
			(down_ff ? $past(MEM_ADDR) - 14'h1 : $past(MEM_ADDR) + 14'h1);
	endproperty
	a_dir: assert property (p_dir)
		else $error("address step wrong");
	property p_io4;
		go && FORMAT[1] && LENGTH_M1 == 8'h03 |=> s_io4;
	endproperty
	a_io4: assert property (p_io4)
		else $error("transfer count wrong");
	property p_bad_nord;
		bad |=> !MEM_RD [*2];
	endproperty
	a_bad_nord: assert property (p_bad_nord)
		else $error("read on bad length");
	property p_bad_err;
		bad |-> ##[1:3] (DONE && FMT_ERR);
	endproperty
	a_bad_err: assert property (p_bad_err)
		else $error("bad length not flagged");
endmodule // hdfu_chk
bind hdfu_unit hdfu_chk hdfu_chk_inst (.CLK(CLK), .SYS_RST(SYS_RST),
	.START(START), .FORMAT(FORMAT), .START_ADDR(START_ADDR),
	.LENGTH_M1(LENGTH_M1), .HB_IN(HB_IN), .HB_VALID(HB_VALID),
	.ERR_CLEAR(ERR_CLEAR), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD),
	.HB_OUT(HB_OUT), .HB_OUT_VALID(HB_OUT_VALID), .BUSY(BUSY),
	.DONE(DONE), .FMT_ERR(FMT_ERR), .PARITY_ERR(PARITY_ERR));
`default_nettype wire

// File: verif/hdfu_mem.sv
// main storage model with combinational byte read
`timescale 1ns/10ps
`default_nettype none
module hdfu_mem (
	input wire logic clk,
	input wire logic [13:0] addr,
	input wire logic rd,
	output logic [7:0] rdata
);
	logic [7:0] mem [0:16383];
	logic [7:0] last_ff = 8'h00;
	initial begin
		for (int k = 0; k < 16384; k++)
			mem[k] = k[7:0] ^ 8'h5A;
	end
	// whole bytes, any pattern; idle bus shows inverse
	assign rdata = rd ? mem[addr] : ~last_ff;
	always @(posedge clk) begin
		if (rd)
			last_ff <= mem[addr];
	end
endmodule // hdfu_mem
`default_nettype wire

// File: verif/tb_top.sv
// self-checking bench for the half-byte format unit
`timescale 1ns/10ps
`default_nettype none
`define CHK(a,e) begin tests_run++; if ((a) !== (e)) begin fails++; \
	$display("MISMATCH %0t %h %h", $time, a, e); end end
module tb_top;
	logic clk, sys_rst, start, alt_code, arith_op, hb_valid, err_clear;
	logic fx_sub, exp_p;
	logic [1:0] format;
	logic [13:0] start_addr;
	logic [7:0] length_m1, r;
	logic [9:0] hb_in;
	logic [15:0] fx_a, fx_b, fx_r;
	logic [3:0] d;
	wire [13:0] mem_addr;
	wire [7:0] mem_rdata;
	wire [9:0] hb_out;
	wire [15:0] fx_result;
	wire mem_rd, hb_out_valid, busy, done, fmt_err, minus, parity_err;
	wire fx_overflow;
	integer fails = 0, tests_run = 0, reads = 0, seed = 32'ha384f8b4, i;
	hdfu_unit hdfu_unit_inst (.CLK(clk), .SYS_RST(sys_rst), .START(start),
		.FORMAT(format), .ALT_CODE(alt_code), .ARITH_OP(arith_op),
		.START_ADDR(start_addr), .LENGTH_M1(length_m1),
		.MEM_RDATA(mem_rdata), .HB_IN(hb_in), .HB_VALID(hb_valid),
		.ERR_CLEAR(err_clear), .FX_A(fx_a), .FX_B(fx_b), .FX_SUB(fx_sub),
		.MEM_ADDR(mem_addr), .MEM_RD(mem_rd), .HB_OUT(hb_out),
		.HB_OUT_VALID(hb_out_valid), .BUSY(busy), .DONE(done),
		.FMT_ERR(fmt_err), .MINUS(minus), .PARITY_ERR(parity_err),
		.FX_RESULT(fx_result), .FX_OVERFLOW(fx_overflow));
	hdfu_mem hdfu_mem_inst (.clk(clk), .addr(mem_addr), .rd(mem_rd),
		.rdata(mem_rdata));
	function automatic logic exp_minus(input logic [3:0] sg, input logic al);
		return al ? (sg == 4'hB || sg == 4'hD) : (sg == 4'hD);
	endfunction
	// signed overflow of a sum or a difference
	function automatic logic exp_ovf(input logic [15:0] a, b, rs,
		input logic s);
		if (s)
			return (a[15] != b[15]) && (rs[15] != a[15]);
		return (a[15] == b[15]) && (rs[15] != a[15]);
	endfunction
	// odd parity per half-byte, upper half first
	function automatic logic [9:0] exp_hb(input logic [7:0] v);
		return {~^v[7:4], v[7:4], ~^v[3:0], v[3:0]};
	endfunction
	task stop_test;
		if (fails == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task run(input logic [1:0] f, input logic ar, input logic [13:0] ad,
		input logic [7:0] ln, input logic al);
		integer k;
		@(negedge clk);
		{format, alt_code, arith_op, start_addr} = {f, al, ar, ad};
		length_m1 = ln;
		start = 1'b1;
		reads = 0;
		@(negedge clk);
		start = 1'b0;
		k = 0;
		do begin @(posedge clk); #1; k++; end while (done !== 1'b1 && k < 400);
		if (done !== 1'b1)
			fails++;
	endtask
	always @(posedge clk) if (mem_rd === 1'b1) reads <= reads + 1;
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		#1000000;
		fails++;
		stop_test;
	end
	initial begin
		{sys_rst, start, format, alt_code, arith_op, start_addr} = 20'h80000;
		{length_m1, hb_in, hb_valid, err_clear, exp_p} = 21'h0;
		{fx_a, fx_b, fx_sub} = 33'h0;
		repeat (3) @(negedge clk);
		sys_rst = 1'b0;
		for (i = 0; i < 64; i++) begin
			d = {$random(seed)} % 10;
			r = $random(seed);
			hdfu_mem_inst.mem[100] = i[5] ? {i[3:0], d} : {d, i[3:0]};
			hdfu_mem_inst.mem[99] = {i[5] ? r[3:0] : 4'h4, 4'h7};
			run({1'b0, i[5]}, 1'b0, 14'h0064, 8'h01, i[4]);
			`CHK(fmt_err, i[3:0] < 4'hA)
			if (i[3:0] >= 4'hA) `CHK(minus, exp_minus(i[3:0], i[4]))
		end
		hdfu_mem_inst.mem[99] = {4'hA + 4'({$random(seed)} % 6), 4'h0};
		hdfu_mem_inst.mem[100] = 8'h0C;
		run(2'h0, 1'b0, 14'h0064, 8'h01, 1'b0);
		`CHK(fmt_err, 1'b1)
		for (i = 284; i <= 300; i++) hdfu_mem_inst.mem[i] = 8'h00;
		for (i = 0; i < 4; i++) begin
			hdfu_mem_inst.mem[300] = i[1] ? 8'hC0 : 8'h0C;
			run({1'b0, i[1]}, 1'b0, 14'd300, 8'h0F + i[0], 1'b0);
			`CHK(fmt_err, i[0])
		end
		run(2'h1, 1'b1, 14'd300, 8'h00, 1'b0);
		`CHK(fmt_err, 1'b1)
		run(2'h3, 1'b0, 14'd400, 8'h03, 1'b0);
		`CHK(reads, 4)
		`CHK(hb_out, exp_hb(hdfu_mem_inst.mem[403]))
		run(2'h2, 1'b0, 14'd400, 8'hFF, 1'b0);
		`CHK(reads, 256)
		for (i = 0; i < 60; i++) begin
			@(negedge clk);
			{hb_in, hb_valid, err_clear} = $random(seed);
			{fx_a, fx_b, fx_sub} = {$random(seed), $random(seed)};
			fx_r = fx_sub ? fx_a - fx_b : fx_a + fx_b;
			@(posedge clk);
			#1;
			if (hb_valid && (~^hb_in[9:5] || ~^hb_in[4:0]))
				exp_p = 1'b1;
			else if (err_clear)
				exp_p = 1'b0;
			`CHK(parity_err, exp_p)
			`CHK(fx_result, fx_r)
			`CHK(fx_overflow, exp_ovf(fx_a, fx_b, fx_r, fx_sub))
		end
		stop_test;
	end
endmodule // tb_top
`default_nettype wire
